/* inc/rpbs_pkg.sv */
// constants and types for the memory pin boundary scan block
package rpbs_pkg;
    // chain length, one cell per monitored pin
    localparam int CHAIN_LEN = 41;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 9;
    // controller timing minima in ns (kept by the controller)
    localparam int SCAN_SETUP_NS = 10;
    localparam int BYPASS_SETUP_NS = 10;
    localparam int SCAN_RECOVERY_NS = 100;
    localparam int SHIFT_SETUP_NS = 10;
    localparam int SHIFT_HOLD_NS = 10;
    localparam int SYS_CLK_NS = 25;
    // cycles at sys_clk, least times rounded up
    localparam int SCAN_RECOVERY_CYC =
        (SCAN_RECOVERY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    // reset values
    localparam logic [CHAIN_LEN-1:0] CHAIN_RST = 41'h000_0000_0000;
    localparam logic SDO_RST = 1'b0;
    // operating states
    typedef enum logic [1:0] {
        RPBS_NORMAL,
        RPBS_SCAN,
        RPBS_BYPASS
    } rpbs_mode_e;
endpackage

/* core/rpbs_sync.sv */
// two flip-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/10ps
module rpbs_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    // first stage feeds only the second stage
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

/* core/rpbs_scan.sv */
// boundary scan chain and mode control for the memory pins
`timescale 1ns/10ps
module rpbs_scan
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [rpbs_pkg::ADDR_W-1:0] mem_addr,
    input wire logic [rpbs_pkg::DATA_W-1:0] mem_din,
    input wire logic [rpbs_pkg::DATA_W-1:0] mem_dout,
    input wire logic mem_chip_en_n,
    input wire logic mem_out_en_n,
    input wire logic mem_write_en_n,
    input wire logic mem_clk,
    input wire logic scan_clk,
    input wire logic scan_capture_block,
    input wire logic scan_serial_in,
    output logic scan_serial_out,
    output logic scan_active,
    output logic bypass_active
);
    import rpbs_pkg::*;

    localparam int NSYNC = ADDR_W + 2 * DATA_W + 7;

    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn;
    logic [ADDR_W-1:0] a_s;
    logic [DATA_W-1:0] d_s;
    logic [DATA_W-1:0] q_s;
    logic e_s, g_s, w_s, k_s, sck_s, se_s, sdi_s;

    // pins only observed, never driven, so memory use is untouched
    assign raw_in = {mem_addr, mem_din, mem_dout, mem_chip_en_n,
                     mem_out_en_n, mem_write_en_n, mem_clk, scan_clk,
                     scan_capture_block, scan_serial_in};

    rpbs_sync #(.W(NSYNC)) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(raw_in),
        .sync_out(syn)
    );

    assign {a_s, d_s, q_s, e_s, g_s, w_s, k_s, sck_s, se_s, sdi_s} = syn;

    // builds the captured word; bit 40 is shifted out first
    function automatic logic [CHAIN_LEN-1:0] pin_word(
        input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d,
        input logic [DATA_W-1:0] q,
        input logic e,
        input logic g,
        input logic w,
        input logic k
    );
        pin_word = {a[6], a[4], a[2], a[0],
                    d[8], q[8], d[6], q[6], d[4], q[4], d[2], q[2],
                    d[0], q[0], a[18], a[1], a[3], a[5], a[7], a[8],
                    a[9], a[10], a[11], a[12], a[13],
                    q[1], d[1], q[3], d[3], q[5], d[5], q[7], d[7],
                    a[15], a[16], a[14], a[17], e, g, w, k};
    endfunction

    // delayed copies of the synchronised clocks for edge detection;
    // only the second synchroniser stage is ever read here
    logic sck_d_r;
    logic sck_d_nxt;
    logic k_d_r;
    logic k_d_nxt;
    logic sck_rise;
    logic sck_fall;
    logic k_rise;

    // one-cycle pulse on a low to high step, so an edge acts only once;
    // swapping the arguments turns it into a falling edge detector
    function automatic logic edge_up(input logic cur, input logic prev);
        edge_up = cur & ~prev;
    endfunction

    // all three edges come through the same two flops, so they line up
    assign sck_rise = edge_up(sck_s, sck_d_r);
    assign sck_fall = edge_up(sck_d_r, sck_s);
    assign k_rise = edge_up(k_s, k_d_r);

    // edge detector next state
    always_comb begin
        sck_d_nxt = sck_s;
        k_d_nxt = k_s;
    end

    // idle level of both clocks is low, so no false edge after reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_d_r <= 1'b0;
            k_d_r <= 1'b0;
        end else begin
            sck_d_r <= sck_d_nxt;
            k_d_r <= k_d_nxt;
        end
    end

    // captured_r marks a capture that no shift or scan clock rise with enable high has followed
    rpbs_mode_e mode_r, mode_nxt;
    logic [CHAIN_LEN-1:0] chain_r, chain_nxt;
    logic captured_r, captured_nxt;
    logic byp_bit_r, byp_bit_nxt;
    logic sdo_r, sdo_nxt;
    logic scan_act_r, scan_act_nxt;
    logic byp_act_r, byp_act_nxt;

    // mode, chain and serial output next-state logic
    always_comb begin
        mode_nxt = mode_r;
        chain_nxt = chain_r;
        captured_nxt = captured_r;
        byp_bit_nxt = byp_bit_r;
        sdo_nxt = sdo_r;
        case (mode_r)
            RPBS_NORMAL: begin
                captured_nxt = 1'b0;
                if (sck_rise && !se_s) begin
                    // first rise: capture now; bypass is told apart later
                    chain_nxt = pin_word(a_s, d_s, q_s, e_s, g_s, w_s,
                                         k_s);
                    captured_nxt = 1'b1;
                    byp_bit_nxt = sdi_s;
                    mode_nxt = RPBS_SCAN;
                end
            end
            RPBS_SCAN: begin
                if (sck_fall && se_s) begin
                    // shift; serial in fills the far end
                    sdo_nxt = chain_r[CHAIN_LEN-1];
                    chain_nxt = {chain_r[CHAIN_LEN-2:0], sdi_s};
                    captured_nxt = 1'b0;
                end else if (sck_fall && !se_s && captured_r) begin
                    // fall after capture with enable still low: bypass
                    sdo_nxt = byp_bit_r;
                    mode_nxt = RPBS_BYPASS;
                end else if (sck_rise && se_s) begin
                    captured_nxt = 1'b0;
                end else if (sck_rise && !se_s && !captured_r) begin
                    // enable low again after shifting: bypass sample
                    byp_bit_nxt = sdi_s;
                    mode_nxt = RPBS_BYPASS;
                end
            end
            RPBS_BYPASS: begin
                if (sck_rise) begin
                    byp_bit_nxt = sdi_s;
                end else if (sck_fall) begin
                    sdo_nxt = byp_bit_r;
                end
            end
            default: begin
                mode_nxt = RPBS_NORMAL;
            end
        endcase
        // memory clock rise with both scan pins low ends scan or bypass;
        // the serial output keeps its last value across the return
        if (k_rise && !sck_s && !se_s) begin
            mode_nxt = RPBS_NORMAL;
            captured_nxt = 1'b0;
        end
    end

    // status flags follow the next mode, so they change together with
    // the mode register and not a cycle after it
    always_comb begin
        scan_act_nxt = (mode_nxt == RPBS_SCAN);
        byp_act_nxt = (mode_nxt == RPBS_BYPASS);
    end

    // status registers drive the status pins directly
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            scan_act_r <= 1'b0;
            byp_act_r <= 1'b0;
        end else begin
            scan_act_r <= scan_act_nxt;
            byp_act_r <= byp_act_nxt;
        end
    end

    // registers for the whole scan state
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_r <= RPBS_NORMAL;
            chain_r <= CHAIN_RST;
            captured_r <= 1'b0;
            byp_bit_r <= 1'b0;
            sdo_r <= SDO_RST;
        end else begin
            mode_r <= mode_nxt;
            chain_r <= chain_nxt;
            captured_r <= captured_nxt;
            byp_bit_r <= byp_bit_nxt;
            sdo_r <= sdo_nxt;
        end
    end

    // outputs straight from flip-flops
    assign scan_serial_out = sdo_r;
    assign scan_active = scan_act_r;
    assign bypass_active = byp_act_r;
endmodule

/* verification/rpbs_scan_properties.sv */
// port checks for the memory pin boundary scan
`timescale 1ns/10ps
module rpbs_scan_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic mem_clk,
    input wire logic scan_clk,
    input wire logic scan_capture_block,
    input wire logic scan_serial_out,
    input wire logic scan_active,
    input wire logic bypass_active
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // pins pass a synchroniser, so outputs trail the pins by 3 cycles; a_capture_rise looks back only 2 and a_bypass_sel checks the enable in the same cycle
    a_one_state: assert property (
        !(scan_active && bypass_active)) else $error("two states");
    a_clock_return: assert property (
        $rose(mem_clk) && !scan_clk && !scan_capture_block ##1
        (!scan_clk && !scan_capture_block)[*4]
        |=> !scan_active && !bypass_active) else $error("no return");
    a_out_steady: assert property (
        scan_clk[*4] |-> $stable(scan_serial_out)) else $error("moved");
    a_capture_rise: assert property (
        $rose(scan_active) |-> $past(scan_clk, 2)) else $error("no rise");
    a_bypass_sel: assert property (
        $rose(bypass_active) |-> !scan_capture_block) else $error("bypass");
    a_scan_keep: assert property (
        (scan_clk && scan_capture_block)[*4] ##0 scan_active
        |=> scan_active) else $error("scan left");
    a_idle_rest: assert property (
        (!scan_active && !bypass_active && !scan_clk)[*5]
        |=> !scan_active && !bypass_active) else $error("left idle");
    a_move_mode: assert property (
        $changed(scan_serial_out) |-> ##[0:1] (scan_active || bypass_active))
        else $error("moved in normal");
endmodule
bind rpbs_scan rpbs_scan_properties chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .mem_clk(mem_clk),
    .scan_clk(scan_clk),
    .scan_capture_block(scan_capture_block),
    .scan_serial_out(scan_serial_out),
    .scan_active(scan_active),
    .bypass_active(bypass_active)
);

/* verification/rpbs_ctrl_model.sv */
// board test controller driving the scan pins
`timescale 1ns/10ps
module rpbs_ctrl_model (
    input wire logic sys_clk,
    output logic scan_clk,
    output logic scan_capture_block,
    output logic scan_serial_in
);
    // quiet pins keep the memory in normal use
    initial begin
        scan_clk = 1'b0;
        scan_capture_block = 1'b0;
        scan_serial_in = 1'b0;
    end
    // one 200 ns scan clock period, 100 ns high and 100 ns low
    task automatic pulse(input logic en_rise, input logic en_fall,
        input logic d);
        scan_capture_block = en_rise;
        scan_serial_in = d;
        repeat (2) @(negedge sys_clk);
        scan_clk = 1'b1;
        repeat (2) @(negedge sys_clk);
        scan_capture_block = en_fall;
        // in bypass the input is dropped once its hold time is over
        if (!en_fall) scan_serial_in = ~d;
        repeat (2) @(negedge sys_clk);
        scan_clk = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask
    // end of scan, then 100 ns recovery before the memory clock resumes
    task automatic rest();
        scan_capture_block = 1'b0;
        scan_serial_in = ~scan_serial_in;
        repeat (4) @(negedge sys_clk);
    endtask
endmodule

/* verification/rpbs_scan_test.sv */
// self-checking bench for the memory pin boundary scan
`timescale 1ns/10ps
module rpbs_scan_test;
    import rpbs_pkg::*;
    logic sys_clk, sys_rst, mem_clk, scan_clk, scan_capture_block;
    logic scan_serial_in, scan_serial_out, scan_active, bypass_active;
    logic mem_chip_en_n, mem_out_en_n, mem_write_en_n;
    logic [ADDR_W-1:0] mem_addr;
    logic [DATA_W-1:0] mem_din, mem_dout;
    logic [127:0] pins;
    logic sdi_q[$];
    int error_cnt = 0, comparisons = 0, cycles = 0;
    // pin codes in output order: address n, data-in 32+n, data-out 64+n
    int ord[CHAIN_LEN] = '{6, 4, 2, 0, 40, 72, 38, 70, 36, 68, 34, 66,
        32, 64, 18, 1, 3, 5, 7, 8, 9, 10, 11, 12, 13, 65, 33, 67, 35, 69,
        37, 71, 39, 15, 16, 14, 17, 96, 97, 98, 99};
    rpbs_scan dut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .mem_addr(mem_addr),
        .mem_din(mem_din),
        .mem_dout(mem_dout),
        .mem_chip_en_n(mem_chip_en_n),
        .mem_out_en_n(mem_out_en_n),
        .mem_write_en_n(mem_write_en_n),
        .mem_clk(mem_clk),
        .scan_clk(scan_clk),
        .scan_capture_block(scan_capture_block),
        .scan_serial_in(scan_serial_in),
        .scan_serial_out(scan_serial_out),
        .scan_active(scan_active),
        .bypass_active(bypass_active)
    );
    rpbs_ctrl_model ctrl (
        .sys_clk(sys_clk),
        .scan_clk(scan_clk),
        .scan_capture_block(scan_capture_block),
        .scan_serial_in(scan_serial_in)
    );
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // hang guard, far above the roughly 1000 cycles of the run
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic check(input string what, input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // new random levels on all monitored pins
    task automatic rand_pins();
        {mem_addr, mem_din, mem_dout} = 37'({$urandom, $urandom});
        {mem_chip_en_n, mem_out_en_n, mem_write_en_n, mem_clk} = 4'($urandom);
    endtask
    // capture, then shift the chain and two serial-in bits behind it
    task automatic scan_frame();
        logic d;
        pins = '0;
        pins[40:0] = {mem_din, 13'h0, mem_addr};
        pins[72:64] = mem_dout;
        pins[99:96] = {mem_clk, mem_write_en_n, mem_out_en_n, mem_chip_en_n};
        sdi_q = {};
        for (int i = 0; i < CHAIN_LEN + 2; i++) begin
            d = 1'($urandom);
            sdi_q.push_back(d);
            if (i > 0) rand_pins();
            ctrl.pulse(i > 0, 1'b1, d);
            repeat (2) @(negedge sys_clk);
            if (i < CHAIN_LEN)
                check("shift", scan_serial_out, pins[ord[i]]);
            else
                check("shift", scan_serial_out, sdi_q[i-CHAIN_LEN]);
        end
        check("scan_active", scan_active, 1'b1);
    endtask
    task automatic bypass_frame(input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            d = 1'($urandom);
            ctrl.pulse(1'b0, 1'b0, d);
            repeat (2) @(negedge sys_clk);
            check("bypass", scan_serial_out, d);
            check("bypass_active", bypass_active, 1'b1);
        end
    endtask
    // memory clock rise with the scan pins low ends scan or bypass
    task automatic to_normal();
        logic held;
        held = scan_serial_out;
        ctrl.rest();
        mem_clk = 1'b0;
        repeat (2) @(negedge sys_clk);
        mem_clk = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("scan_active", scan_active, 1'b0);
        check("bypass_active", bypass_active, 1'b0);
        check("held", scan_serial_out, held);
    endtask
    initial begin
        void'($urandom(32'h0d81717e));
        sys_rst = 1'b1;
        rand_pins();
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int f = 0; f < 2; f++) begin
            rand_pins();
            repeat (4) @(negedge sys_clk);
            scan_frame();
            bypass_frame(3);
            to_normal();
            bypass_frame(2);
            to_normal();
        end
        close_out();
    end
endmodule
